// ==== core/strtc_top.sv ====
`timescale 1ns/1ps
`include "strtc_cfg.svh"

// What this block does
// - Wake output bit drives enabled wake pin
// - Seconds enable gives edge interrupt each second
// - Alarm flag gated by alarm enable
// - Overflow flag gated by overflow enable
// - Invalid flag gated by invalid enable
// - Enable register upper bits read zero
// - Counter runs from crystal clock, only while oscillator enabled
// - Power-on and soft reset restore defaults
// - Oscillator starts disabled, software enables it
// - Soft reset bit resets rest, keeps itself
// - Protected writes need supervisor, else error
// - 32-bit seconds, 16-bit prescaler counters
// - Counter writes only while counter disabled
// - Seconds step on prescaler bit falling
// - Prescaler runs when enabled, valid, clocked
// - Seconds wrap sets overflow, stops prescaler
// - Overflow reads zero; seconds write clears
// - Invalid set by resets, cleared by write
// - Interrupt when flag and enable both set
// - Alarm sets on match at step; write clears
// - Disabled counter writable; enabled counter counts
module strtc_top (
  input  wire logic                    i_clk,
  input  wire logic                    i_reset_n,
  input  wire strtc_pkg::strtc_bus_req_t i_bus,
  input  wire logic                    i_osc_clk,
  input  wire logic                    i_wake_pin_enable,
  output logic [31:0]                  o_rdata,
  output logic                         o_bus_error,
  output logic                         o_irq,
  output logic                         o_seconds_irq,
  output logic                         o_wake_pin,
  output logic                         o_osc_enable
);

  // ----------------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------------
  // True when the bus address selects the given register
  function automatic logic strtc_hit(input logic [`STRTC_ADDR_W-1:0] addr,
                                     input logic [`STRTC_ADDR_W-1:0] ofs);
    strtc_hit = (addr == ofs);
  endfunction : strtc_hit

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic                    soft_reset_q;     // Soft reset bit, cleared by POR or control write
  logic                    soft_reset_d;
  logic                    super_access_q;   // One lets any mode write
  logic                    super_access_d;
  logic                    osc_enable_q;     // Crystal oscillator enable
  logic                    osc_enable_d;
  strtc_pkg::strtc_status_t status_q;        // Flags and counter enable
  strtc_pkg::strtc_status_t status_d;
  strtc_pkg::strtc_ier_t   ier_q;            // Interrupt enables
  strtc_pkg::strtc_ier_t   ier_d;
  logic [31:0]             seconds_count_q;  // Seconds counter
  logic [31:0]             seconds_count_d;
  logic [15:0]             prescaler_count_q;// Prescaler counter
  logic [15:0]             prescaler_count_d;
  logic [31:0]             alarm_value_q;    // Alarm compare value
  logic [31:0]             alarm_value_d;
  logic                    osc_prev_q;       // Last sample of crystal clock
  logic [31:0]             rdata_q;          // Read data register
  logic [31:0]             rdata_d;
  logic                    bus_error_q;      // Bus error pulse
  logic                    bus_error_d;
  logic                    irq_q;            // Main interrupt request
  logic                    irq_d;
  logic                    seconds_irq_q;    // Seconds interrupt pulse
  logic                    seconds_irq_d;
  logic                    wake_pin_q;       // Wake pin drive
  logic                    wake_pin_d;

  // ----------------------------------------------------------------------
  // Counting terms
  // ----------------------------------------------------------------------
  logic                    wr_ok;            // Write allowed by privilege
  logic                    osc_edge;         // Rising edge of crystal clock
  logic                    counter_run;      // Prescaler may advance
  logic                    pre_tick;         // Prescaler advances this cycle
  logic [15:0]             pre_inc;          // Prescaler plus one
  logic                    sec_step;         // Seconds advance this cycle
  logic                    time_hidden;      // Counters read as zero
  logic [2:0]              irq_src;          // Per-source request terms
  logic [2:0]              flag_vec;         // Flags feeding request
  logic [2:0]              en_vec;           // Enables feeding request

  // Privilege check on writes
  assign wr_ok       = i_bus.wr & (super_access_q | i_bus.supervisor);
  // Crystal clock present only when the oscillator is on
  assign osc_edge    = osc_enable_q & i_osc_clk & ~osc_prev_q;
  assign counter_run = status_q.counter_enable & ~status_q.invalid_time_flag
                       & ~status_q.overflow_flag;
  assign pre_tick    = counter_run & osc_edge;
  assign pre_inc     = prescaler_count_q + `STRTC_ONE16;
  // Seconds advance when prescaler bit falls from one to zero
  assign sec_step    = pre_tick & prescaler_count_q[`STRTC_PRE_STEP_BIT]
                       & ~pre_inc[`STRTC_PRE_STEP_BIT];
  assign time_hidden = status_q.invalid_time_flag | status_q.overflow_flag;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Prescaler advance, bus writes, seconds step, soft reset, control write, in rising priority
  always_comb begin
    soft_reset_d      = soft_reset_q;
    super_access_d    = super_access_q;
    osc_enable_d      = osc_enable_q;
    status_d          = status_q;
    ier_d             = ier_q;
    seconds_count_d   = seconds_count_q;
    prescaler_count_d = prescaler_count_q;
    alarm_value_d     = alarm_value_q;
    // Prescaler advance
    if (pre_tick) begin
      prescaler_count_d = pre_inc;
    end
    // Counter writes only while counter disabled
    if (wr_ok && !status_q.counter_enable) begin
      if (strtc_hit(i_bus.addr, `STRTC_OFS_PRESCALER)) begin
        prescaler_count_d = i_bus.wdata[15:0];
      end
      if (strtc_hit(i_bus.addr, `STRTC_OFS_SECONDS)) begin
        seconds_count_d            = i_bus.wdata;
        status_d.overflow_flag     = 1'b0;
        status_d.invalid_time_flag = 1'b0;
      end
    end
    // Alarm write clears the flag
    if (wr_ok && strtc_hit(i_bus.addr, `STRTC_OFS_ALARM)) begin
      alarm_value_d       = i_bus.wdata;
      status_d.alarm_flag = 1'b0;
    end
    // Only the counter enable is writable in the status register
    if (wr_ok && strtc_hit(i_bus.addr, `STRTC_OFS_STATUS)) begin
      status_d.counter_enable = i_bus.wdata[`STRTC_SR_COUNTER_EN];
    end
    // Interrupt enable write
    if (wr_ok && strtc_hit(i_bus.addr, `STRTC_OFS_IER)) begin
      ier_d.wake_output_on      = i_bus.wdata[`STRTC_IER_WAKE];
      ier_d.seconds_irq_enable  = i_bus.wdata[`STRTC_IER_SECONDS];
      ier_d.alarm_irq_enable    = i_bus.wdata[`STRTC_IER_ALARM];
      ier_d.overflow_irq_enable = i_bus.wdata[`STRTC_IER_OVERFLOW];
      ier_d.invalid_irq_enable  = i_bus.wdata[`STRTC_IER_INVALID];
    end
    // Seconds step; alarm set wins over a same-cycle clear
    if (sec_step) begin
      if (alarm_value_q == seconds_count_q) begin
        status_d.alarm_flag = 1'b1;
      end
      if (seconds_count_q == `STRTC_SEC_MAX) begin
        seconds_count_d        = `STRTC_ZERO32;
        status_d.overflow_flag = 1'b1;
      end else begin
        seconds_count_d = seconds_count_q + `STRTC_ONE32;
      end
    end
    // Soft reset holds everything but itself at defaults
    if (soft_reset_q) begin
      super_access_d             = 1'b0;
      osc_enable_d               = 1'b0;
      status_d                   = '0;
      status_d.invalid_time_flag = 1'b1;
      ier_d                      = `STRTC_IER_RESET;
      seconds_count_d            = `STRTC_ZERO32;
      prescaler_count_d          = `STRTC_ZERO16;
      alarm_value_d              = `STRTC_ZERO32;
    end
    // Control write, also allowed while in soft reset so it can be left
    if (wr_ok && strtc_hit(i_bus.addr, `STRTC_OFS_CONTROL)) begin
      soft_reset_d   = i_bus.wdata[`STRTC_CR_SOFT_RESET];
      super_access_d = i_bus.wdata[`STRTC_CR_SUPER_ACCESS];
      osc_enable_d   = i_bus.wdata[`STRTC_CR_OSC_ENABLE];
    end
  end

  // Registers of the counter and control state
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      soft_reset_q               <= 1'b0;
      super_access_q             <= 1'b0;
      osc_enable_q               <= 1'b0;
      status_q                   <= '0;
      status_q.invalid_time_flag <= 1'b1;
      ier_q                      <= `STRTC_IER_RESET;
      seconds_count_q            <= `STRTC_ZERO32;
      prescaler_count_q          <= `STRTC_ZERO16;
      alarm_value_q              <= `STRTC_ZERO32;
      osc_prev_q                 <= 1'b0;
    end else begin
      soft_reset_q      <= soft_reset_d;
      super_access_q    <= super_access_d;
      osc_enable_q      <= osc_enable_d;
      status_q          <= status_d;
      ier_q             <= ier_d;
      seconds_count_q   <= seconds_count_d;
      prescaler_count_q <= prescaler_count_d;
      alarm_value_q     <= alarm_value_d;
      osc_prev_q        <= i_osc_clk;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------------
  assign flag_vec = {status_d.alarm_flag, status_d.overflow_flag,
                     status_d.invalid_time_flag};
  assign en_vec   = {ier_d.alarm_irq_enable, ier_d.overflow_irq_enable,
                     ier_d.invalid_irq_enable};

  // One gated term per flag
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_irq_src
      assign irq_src[gi] = flag_vec[gi] & en_vec[gi];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Output and read-back logic
  // ----------------------------------------------------------------------
  // Next values of the registered outputs
  always_comb begin
    irq_d         = |irq_src;
    seconds_irq_d = sec_step & ier_q.seconds_irq_enable & ~soft_reset_q;
    wake_pin_d    = ier_q.wake_output_on & i_wake_pin_enable;
    bus_error_d   = i_bus.wr & ~wr_ok;
    rdata_d       = `STRTC_ZERO32;
    // Reads are open to every mode
    if (i_bus.rd) begin
      case (i_bus.addr)
        `STRTC_OFS_SECONDS: begin
          rdata_d = time_hidden ? `STRTC_ZERO32 : seconds_count_q;
        end
        `STRTC_OFS_PRESCALER: begin
          rdata_d[15:0] = time_hidden ? `STRTC_ZERO16 : prescaler_count_q;
        end
        `STRTC_OFS_ALARM: begin
          rdata_d = alarm_value_q;
        end
        `STRTC_OFS_CONTROL: begin
          rdata_d[`STRTC_CR_SOFT_RESET]   = soft_reset_q;
          rdata_d[`STRTC_CR_SUPER_ACCESS] = super_access_q;
          rdata_d[`STRTC_CR_OSC_ENABLE]   = osc_enable_q;
        end
        `STRTC_OFS_STATUS: begin
          rdata_d[`STRTC_SR_INVALID]    = status_q.invalid_time_flag;
          rdata_d[`STRTC_SR_OVERFLOW]   = status_q.overflow_flag;
          rdata_d[`STRTC_SR_ALARM]      = status_q.alarm_flag;
          rdata_d[`STRTC_SR_COUNTER_EN] = status_q.counter_enable;
        end
        `STRTC_OFS_IER: begin
          // Upper bits stay zero
          rdata_d[`STRTC_IER_WAKE]     = ier_q.wake_output_on;
          rdata_d[`STRTC_IER_SECONDS]  = ier_q.seconds_irq_enable;
          rdata_d[`STRTC_IER_ALARM]    = ier_q.alarm_irq_enable;
          rdata_d[`STRTC_IER_OVERFLOW] = ier_q.overflow_irq_enable;
          rdata_d[`STRTC_IER_INVALID]  = ier_q.invalid_irq_enable;
        end
        default: begin
          // Unmapped addresses read zero
          rdata_d = `STRTC_ZERO32;
        end
      endcase
    end
  end

  // Output registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_q         <= 1'b1;
      seconds_irq_q <= 1'b0;
      wake_pin_q    <= 1'b0;
      bus_error_q   <= 1'b0;
      rdata_q       <= `STRTC_ZERO32;
    end else begin
      irq_q         <= irq_d;
      seconds_irq_q <= seconds_irq_d;
      wake_pin_q    <= wake_pin_d;
      bus_error_q   <= bus_error_d;
      rdata_q       <= rdata_d;
    end
  end

  assign o_rdata       = rdata_q;
  assign o_bus_error   = bus_error_q;
  assign o_irq         = irq_q;
  assign o_seconds_irq = seconds_irq_q;
  assign o_wake_pin    = wake_pin_q;
  assign o_osc_enable  = osc_enable_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  property p_wake_pin;
    ier_q.wake_output_on && i_wake_pin_enable && !soft_reset_q |=> o_wake_pin;
  endproperty
  a_wake_pin: assert property (p_wake_pin) else $error("wake pin not driven");

  property p_seconds_irq;
    sec_step && ier_q.seconds_irq_enable && !soft_reset_q |=> o_seconds_irq ##1 !o_seconds_irq;
  endproperty
  a_seconds_irq: assert property (p_seconds_irq) else $error("seconds irq missing");

  property p_seconds_pulse;
    o_seconds_irq |-> $past(seconds_count_q) != seconds_count_q || status_q.overflow_flag;
  endproperty
  a_seconds_pulse: assert property (p_seconds_pulse) else $error("seconds irq without step");

  property p_alarm_irq;
    status_q.alarm_flag && ier_q.alarm_irq_enable |-> o_irq;
  endproperty
  a_alarm_irq: assert property (p_alarm_irq) else $error("alarm irq missing");

  property p_overflow_irq;
    status_q.overflow_flag && ier_q.overflow_irq_enable |-> o_irq;
  endproperty
  a_overflow_irq: assert property (p_overflow_irq) else $error("overflow irq missing");

  property p_invalid_irq;
    status_q.invalid_time_flag && ier_q.invalid_irq_enable |-> o_irq;
  endproperty
  a_invalid_irq: assert property (p_invalid_irq) else $error("invalid irq missing");

  property p_irq_quiet;
    !(|({status_q.alarm_flag, status_q.overflow_flag, status_q.invalid_time_flag}
        & {ier_q.alarm_irq_enable, ier_q.overflow_irq_enable, ier_q.invalid_irq_enable}))
    |-> !o_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq without source");

  property p_ier_reserved;
    i_bus.rd && i_bus.addr == `STRTC_OFS_IER |=> o_rdata[31:8] == 24'h00_0000;
  endproperty
  a_ier_reserved: assert property (p_ier_reserved) else $error("ier reserved bits set");

  property p_bus_error;
    i_bus.wr && !super_access_q && !i_bus.supervisor |=> o_bus_error;
  endproperty
  a_bus_error: assert property (p_bus_error) else $error("bus error missing");

  property p_hidden_read;
    i_bus.rd && i_bus.addr == `STRTC_OFS_SECONDS && time_hidden |=> o_rdata == `STRTC_ZERO32;
  endproperty
  a_hidden_read: assert property (p_hidden_read) else $error("hidden time read nonzero");

  property p_locked_write;
    status_q.counter_enable && i_bus.wr && !sec_step && !soft_reset_q
    && i_bus.addr == `STRTC_OFS_SECONDS |=> $stable(seconds_count_q);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("write while enabled");

  property p_step;
    sec_step && seconds_count_q != `STRTC_SEC_MAX && !soft_reset_q
    |=> seconds_count_q == $past(seconds_count_q) + `STRTC_ONE32;
  endproperty
  a_step: assert property (p_step) else $error("seconds did not step");

  property p_overflow;
    sec_step && seconds_count_q == `STRTC_SEC_MAX && !soft_reset_q
    |=> status_q.overflow_flag ##1 $stable(prescaler_count_q);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_soft_reset;
    soft_reset_q |=> status_q.invalid_time_flag && !status_q.counter_enable && soft_reset_q
                     || !soft_reset_q;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not applied");

  c_step:     cover property (sec_step);
  c_overflow: cover property (sec_step && seconds_count_q == `STRTC_SEC_MAX);
  c_alarm:    cover property (sec_step && alarm_value_q == seconds_count_q);
  c_sec_irq:  cover property (o_seconds_irq);

endmodule : strtc_top

// ==== core/strtc_cfg.svh ====
`ifndef STRTC_CFG_SVH
`define STRTC_CFG_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define STRTC_ADDR_W          8
`define STRTC_OFS_SECONDS     8'h00
`define STRTC_OFS_PRESCALER   8'h04
`define STRTC_OFS_ALARM       8'h08
`define STRTC_OFS_CONTROL     8'h10
`define STRTC_OFS_STATUS      8'h14
`define STRTC_OFS_IER         8'h1C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define STRTC_CR_SOFT_RESET   0
`define STRTC_CR_SUPER_ACCESS 1
`define STRTC_CR_OSC_ENABLE   8
`define STRTC_SR_INVALID      0
`define STRTC_SR_OVERFLOW     1
`define STRTC_SR_ALARM        2
`define STRTC_SR_COUNTER_EN   4
`define STRTC_IER_INVALID     0
`define STRTC_IER_OVERFLOW    1
`define STRTC_IER_ALARM       2
`define STRTC_IER_SECONDS     4
`define STRTC_IER_WAKE        7
`define STRTC_PRE_STEP_BIT    14

// ----------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------
`define STRTC_IER_RESET       5'h07
`define STRTC_ZERO32          32'h0000_0000
`define STRTC_ONE32           32'h0000_0001
`define STRTC_SEC_MAX         32'hFFFF_FFFF
`define STRTC_ZERO16          16'h0000
`define STRTC_ONE16           16'h0001

`endif

// ==== core/strtc_pkg.sv ====
`include "strtc_cfg.svh"

package strtc_pkg;

  // ----------------------------------------------------------------------
  // Register bus request carried as one bundle
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [`STRTC_ADDR_W-1:0] addr;        // Byte address
    logic [31:0]              wdata;       // Write data
    logic                     wr;          // Write strobe
    logic                     rd;          // Read strobe
    logic                     supervisor;  // Access made in supervisor mode
  } strtc_bus_req_t;

  // Status register contents
  typedef struct packed {
    logic counter_enable;
    logic alarm_flag;
    logic overflow_flag;
    logic invalid_time_flag;
  } strtc_status_t;

  // Interrupt enable register contents
  typedef struct packed {
    logic wake_output_on;
    logic seconds_irq_enable;
    logic alarm_irq_enable;
    logic overflow_irq_enable;
    logic invalid_irq_enable;
  } strtc_ier_t;

endpackage : strtc_pkg

// ==== sim/strtc_tb.sv ====
`timescale 1ns/1ps
`include "strtc_cfg.svh"
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("BAD %0t %s", $time, msg); end end

module tb;
  // ----------------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------------
  logic                      i_clk;       // Bus clock
  logic                      i_reset_n;   // Power-on reset, active low
  strtc_pkg::strtc_bus_req_t bus;         // Register bus request
  logic                      osc;         // Crystal clock stand-in
  logic                      wake_en;     // Wake pin feature enable
  logic [31:0]               rdata;       // Read data
  logic                      bus_err;     // Refused write pulse
  logic                      irq;         // Main interrupt
  logic                      sec_irq;     // Seconds pulse
  logic                      wake;        // Wake pin
  logic                      osc_en;      // Oscillator enable
  logic                      rd_pend;     // Read answer due this cycle
  logic [31:0]               exp_q[$];    // Expected read data, oldest first
  logic [31:0]               rnd;         // Random alarm pattern
  int                        n_fail;      // Mismatches
  int                        num_checks;  // Comparisons
  int                        sec_pulses;  // Seconds pulses seen
  integer                    seed;        // Random seed

  strtc_top i_strtc_top (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_bus(bus), .i_osc_clk(osc),
    .i_wake_pin_enable(wake_en), .o_rdata(rdata), .o_bus_error(bus_err), .o_irq(irq),
    .o_seconds_irq(sec_irq), .o_wake_pin(wake), .o_osc_enable(osc_en));

  // Bus clock, 5 ns period
  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Watcher: compares read data against the oldest note, counts pulses
  always @(posedge i_clk) begin
    if (rd_pend === 1'h1) `CHK(rdata, exp_q.pop_front(), "read data mismatch")
    rd_pend <= bus.rd;
    if (sec_irq === 1'h1) sec_pulses++;
  end

  // ----------------------------------------------------------------------
  // Bus and crystal tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic sup);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0, supervisor: sup};
    @(posedge i_clk);
    bus.wr <= 1'h0;
  endtask : wr

  // Reads go out in user mode, which is always allowed
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1, supervisor: 1'h0};
    @(posedge i_clk);
    bus.rd <= 1'h0;
  endtask : rd

  // Each pulse gives one sampled rising crystal edge
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge i_clk);
      osc <= 1'h1;
      repeat (2) @(posedge i_clk);
      osc <= 1'h0;
      @(posedge i_clk);
    end
  endtask : pulses

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    i_reset_n = 1'h0; bus = '0; osc = 1'h0; wake_en = 1'h1; rd_pend = 1'h0;
    n_fail = 0; num_checks = 0; sec_pulses = 0; seed = 32'h3b63;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'h1;
    #1 `CHK(irq, 1'h1, "irq low after reset")
    `CHK(osc_en, 1'h0, "oscillator on after reset")
    rd(`STRTC_OFS_IER, 32'h07);
    rd(`STRTC_OFS_STATUS, 32'h01);
    // User-mode write is refused while protection is on
    wr(`STRTC_OFS_IER, 32'hFFFF_FFFF, 1'h0);
    #1 `CHK(bus_err, 1'h1, "no bus error")
    rd(`STRTC_OFS_IER, 32'h07);
    wr(`STRTC_OFS_IER, 32'hFFFF_FFFF, 1'h1);
    rd(`STRTC_OFS_IER, 32'h97);
    #1 `CHK(wake, 1'h1, "wake pin not asserted")
    @(posedge i_clk) wake_en <= 1'h0;
    repeat (2) @(posedge i_clk);
    #1 `CHK(wake, 1'h0, "wake pin with feature off")
    // Invalid flag gated by its enable
    wr(`STRTC_OFS_IER, 32'h06, 1'h1);
    repeat (2) @(posedge i_clk);
    #1 `CHK(irq, 1'h0, "irq with enable clear")
    rnd = $random(seed);
    wr(`STRTC_OFS_ALARM, rnd, 1'h1);
    rd(`STRTC_OFS_ALARM, rnd);
    // Prescaler first, then seconds near the wrap point
    wr(`STRTC_OFS_PRESCALER, 32'h7FF0, 1'h1);
    wr(`STRTC_OFS_SECONDS, 32'hFFFF_FFFF, 1'h1);
    rd(`STRTC_OFS_STATUS, 32'h00);
    rd(`STRTC_OFS_SECONDS, 32'hFFFF_FFFF);
    // Pulses leave a disabled counter still; the seconds write once enabled is ignored
    wr(`STRTC_OFS_CONTROL, 32'h100, 1'h1);
    #1 `CHK(osc_en, 1'h1, "oscillator enable")
    pulses(3);
    rd(`STRTC_OFS_PRESCALER, 32'h7FF0);
    wr(`STRTC_OFS_ALARM, 32'hFFFF_FFFF, 1'h1);
    wr(`STRTC_OFS_IER, 32'h16, 1'h1);
    wr(`STRTC_OFS_STATUS, 32'h10, 1'h1);
    wr(`STRTC_OFS_SECONDS, 32'h5, 1'h1);
    pulses(15);
    `CHK(sec_pulses, 0, "early seconds step")
    pulses(1);
    repeat (3) @(posedge i_clk);
    `CHK(sec_pulses, 1, "seconds pulse count")
    rd(`STRTC_OFS_STATUS, 32'h16);
    rd(`STRTC_OFS_SECONDS, 32'h0);
    rd(`STRTC_OFS_PRESCALER, 32'h0);
    #1 `CHK(irq, 1'h1, "irq with overflow")
    // Soft reset restores defaults but keeps its own bit
    wr(`STRTC_OFS_CONTROL, 32'h1, 1'h1);
    rd(`STRTC_OFS_IER, 32'h07);
    rd(`STRTC_OFS_CONTROL, 32'h1);
    rd(`STRTC_OFS_STATUS, 32'h01);
    #1 `CHK(irq, 1'h1, "irq low in soft reset")
    wr(`STRTC_OFS_CONTROL, 32'h0, 1'h1);
    // Open writes to user mode, then one step without wrap
    wr(`STRTC_OFS_CONTROL, 32'h102, 1'h1);
    wr(`STRTC_OFS_PRESCALER, 32'h7FFF, 1'h0);
    #1 `CHK(bus_err, 1'h0, "user write refused")
    rnd = ($random(seed) & 32'h7FFF_FFFF) | 32'h1;
    wr(`STRTC_OFS_SECONDS, rnd, 1'h0);
    wr(`STRTC_OFS_STATUS, 32'h10, 1'h0);
    pulses(1);
    `CHK(sec_pulses, 1, "seconds pulse while disabled")
    rd(`STRTC_OFS_SECONDS, rnd + 32'h1);
    rd(`STRTC_OFS_SECONDS, rnd + 32'h1);
    rd(`STRTC_OFS_PRESCALER, 32'h8000);
    #1 `CHK(irq, 1'h0, "irq without source")
    repeat (3) @(posedge i_clk);
    tally_and_finish();
  end

  // Watchdog against a hang
  initial begin
    #20000;
    n_fail++;
    tally_and_finish();
  end
endmodule : tb
